// ---- bench/keypad_model.sv ----
/*
 * keypad partner: eight switches to ground with pull-ups.
 * assumes press_in comes from the bench, one bit per key.
 */
module keypad_model (
    input wire logic [7:0] press_in,
    output logic [7:0] keys_out
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // a pressed key pulls its line low, a released one floats to the pull-up
    assign keys_out = ~press_in;
endmodule

// ---- bench/keypad_pattern_interrupt_bench.sv ----
/*
 * self-checking bench for the keypad pattern interrupt unit.
 * assumes the zero-wait apb slave and register map of the design.
 */
`include "kpi_defines.svh"

module keypad_pattern_interrupt_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // 40 mhz system clock
    logic rstn = 1'b0; // active low reset
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] press = 8'h00; // keys held down
    logic [7:0] keys;
    logic baud = 1'b0; // baud overflow pulse
    logic idle = 1'b0;
    logic pdown = 1'b0;
    logic key_irq;
    logic wake;
    logic irq;
    logic [31:0] rd; // last read word
    logic err; // last slave error
    int err_total = 0;
    int num_checks = 0;

    always #12.5 clk = ~clk;

    keypad_model u_keys (.press_in(press), .keys_out(keys));
    keypad_pattern_interrupt u_dut (
        .ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'h1),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .keypad_input_in(keys), .baud_tick_in(baud), .idle_in(idle),
        .powerdown_in(pdown), .key_irq_out(key_irq), .wake_out(wake), .irq_out(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // verdict, reached from the end of the run and from any timeout
    task automatic summarize();
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 40) begin
            err_total++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // read the flag bit of the control register after the keys settle
    task automatic flag_is(input logic exp);
        cyc(12);
        apb(1'b0, `KPI_OFF_CTRL, 32'h0);
        check({31'h0, rd[`KPI_CTRL_FLAG]}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reset values and an unmapped address
    task automatic t_reset();
        apb(1'b0, `KPI_OFF_PATTERN, 32'h0);
        check(rd, 32'h000000ff);
        apb(1'b0, `KPI_OFF_CTRL, 32'h0);
        check(rd, 32'h00000001);
        apb(1'b0, `KPI_OFF_MASK, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask

    // keyboard set-up: masked key ignored, enabled key sets flag and locks
    task automatic t_keyboard();
        apb(1'b1, `KPI_OFF_CTRL, 32'h0); // not-equal polarity, flag cleared
        apb(1'b1, `KPI_OFF_MASK, 32'h01);
        apb(1'b1, `KPI_OFF_IRQEN, 32'h3);
        apb(1'b1, `KPI_OFF_IMASK, 32'h1);
        apb(1'b1, `KPI_OFF_PATTERN, 32'hff);
        press <= 8'h02;
        flag_is(1'b0);
        check({31'h0, key_irq}, 32'h0);
        press <= 8'h03;
        flag_is(1'b1);
        check({31'h0, key_irq}, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, `KPI_OFF_CTRL, 32'h0);
        flag_is(1'b0);
        apb(1'b1, `KPI_OFF_PATTERN, 32'hff);
        flag_is(1'b1);
    endtask

    // global enable gates the request, sleep modes raise wake, w1c status
    task automatic t_irq();
        apb(1'b1, `KPI_OFF_IRQEN, 32'h1);
        cyc(3);
        check({31'h0, key_irq}, 32'h0);
        idle <= 1'b1;
        cyc(3);
        check({31'h0, wake}, 32'h1);
        idle <= 1'b0;
        pdown <= 1'b1;
        cyc(3);
        check({31'h0, wake}, 32'h1);
        pdown <= 1'b0;
        apb(1'b1, `KPI_OFF_STATUS, 32'h3);
        cyc(3);
        check({31'h0, irq}, 32'h0);
        check({31'h0, wake}, 32'h0);
    endtask

    // equal polarity fires only on an exact masked match
    task automatic t_polarity();
        press <= 8'h00;
        apb(1'b1, `KPI_OFF_CTRL, 32'h2);
        apb(1'b1, `KPI_OFF_MASK, 32'hff);
        apb(1'b1, `KPI_OFF_PATTERN, 32'ha5);
        flag_is(1'b0);
        press <= 8'h5a;
        flag_is(1'b1);
    endtask

    // baud-tick filter holds the key back until three ticks have passed
    task automatic t_filter();
        press <= 8'h00;
        apb(1'b1, `KPI_OFF_CTRL, 32'hc0);
        apb(1'b1, `KPI_OFF_MASK, 32'h01);
        apb(1'b1, `KPI_OFF_PATTERN, 32'hff);
        cyc(4);
        repeat (4) begin
            baud <= 1'b1;
            cyc(1);
            baud <= 1'b0;
            cyc(2);
        end
        press <= 8'h01;
        flag_is(1'b0);
        repeat (2) begin
            baud <= 1'b1;
            cyc(1);
            baud <= 1'b0;
            cyc(2);
        end
        flag_is(1'b0);
        baud <= 1'b1;
        cyc(1);
        baud <= 1'b0;
        flag_is(1'b1);
    endtask

    // edge mode: a condition already true at rearm is no event, a new press is
    task automatic t_edge();
        apb(1'b1, `KPI_OFF_CTRL, 32'h20);
        apb(1'b1, `KPI_OFF_PATTERN, 32'hff);
        flag_is(1'b0);
        press <= 8'h00;
        cyc(8);
        press <= 8'h01;
        flag_is(1'b1);
    endtask

    // clock filter drops a two-cycle glitch; the divided filter is slower
    task automatic t_modes();
        press <= 8'h00;
        apb(1'b1, `KPI_OFF_CTRL, 32'h40);
        cyc(8);
        apb(1'b1, `KPI_OFF_PATTERN, 32'hff);
        press <= 8'h01;
        cyc(2);
        press <= 8'h00;
        flag_is(1'b0);
        press <= 8'h01;
        flag_is(1'b1);
        apb(1'b1, `KPI_OFF_CTRL, 32'h80);
        press <= 8'h00;
        cyc(30);
        apb(1'b1, `KPI_OFF_PATTERN, 32'hff);
        press <= 8'h01;
        flag_is(1'b0);
        flag_is(1'b1);
    endtask

    initial begin
        cyc(6);
        rstn <= 1'b1;
        t_reset();
        t_keyboard();
        t_irq();
        t_polarity();
        t_filter();
        t_edge();
        t_modes();
        summarize();
    end
endmodule

// ---- verilog/key_input_filter.sv ----
/*
 * one keypad input: three-flop synchroniser then a glitch filter that
 * takes a new level only after it has stood for a number of sample ticks.
 * assumes tick_in is a one-cycle pulse on ref_clk_in.
 */
`include "kpi_defines.svh"

module key_input_filter
    import kpi_pkg::*;
#(
    parameter int FILTER_TICKS = `KPI_FILTER_TICKS
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    input wire logic tick_in,
    input wire logic bypass_in,
    output logic sync_out,
    output logic level_out
);
    localparam int CW = $clog2(FILTER_TICKS + 1);

    // the counter must reach at least one tick
    initial begin
        if (FILTER_TICKS < 1) begin
            $error("FILTER_TICKS must be at least 1");
        end
    end

    logic s1_q; // first stage, read only by s2_q
    logic s2_q;
    logic s3_q;
    logic clean_q; // value once the second and third stages agree
    logic level_q; // filtered level
    logic [CW-1:0] cnt_q; // ticks the new level has stood

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser; idle keys are pulled high, so reset to one
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            clean_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts only once two stages agree
            if (s2_q == s3_q) begin
                clean_q <= s3_q; // RULE14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // filter: a return to the held level restarts the count, so a glitch is dropped
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_q <= 1'b1;
            cnt_q <= '0;
        end else if (bypass_in) begin
            level_q <= clean_q; // RULE10
            cnt_q <= '0;
        end else if (clean_q == level_q) begin
            cnt_q <= '0;
        end else if (tick_in) begin
            if (cnt_q == CW'(FILTER_TICKS - 1)) begin
                level_q <= clean_q; // RULE10
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign sync_out = clean_q;
    assign level_out = level_q;

    // filtered level only moves on a tick or when bypassed
    a_filter_tick: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $changed(level_q) |-> $past(tick_in) || $past(bypass_in)) // RULE10
        else $error("filtered level moved without a tick");

    // clean value only moves when two synchroniser stages agreed
    a_sync_agree: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $changed(clean_q) |-> $past(s2_q) == $past(s3_q)) // RULE14
        else $error("input taken before synchroniser settled");
endmodule

// ---- verilog/keypad_pattern_interrupt.sv ----
/*
 * keypad pattern-match interrupt unit with an apb register slave.
 * assumes an apb master on ref_clk_in, keypad pins asynchronous to it,
 * and baud_tick_in, idle_in and powerdown_in from logic on the same clock.
 */
// The implementer's own choices: the APB slave port and the address map.
`include "kpi_defines.svh"

module keypad_pattern_interrupt
    import kpi_pkg::*;
#(
    parameter int NUM_KEYS = 8,
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // keypad side
    input wire logic [NUM_KEYS-1:0] keypad_input_in,
    input wire logic baud_tick_in,
    input wire logic idle_in,
    input wire logic powerdown_in,
    // requests
    output logic key_irq_out,
    output logic wake_out,
    output logic irq_out
);
    // the pattern and mask registers are one byte wide
    initial begin
        if (NUM_KEYS != 8) begin
            $error("NUM_KEYS must be 8");
        end
        if (ADDR_W < 5) begin
            $error("ADDR_W too small for the register map");
        end
    end

    localparam int DCW = $clog2(`KPI_DIV_RATIO);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] key_match_pattern_q; // compare value
    logic [7:0] key_input_enable_mask_q; // per-input participation
    logic key_match_flag_q; // sticky match flag
    logic match_polarity_select_q; // 1 equal, 0 not equal
    logic key_edge_mode_select_q; // 1 edge, 0 level
    filter_mode_e key_filter_select_q; // filter source
    logic key_irq_enable_q;
    logic global_irq_enable_q;
    logic [1:0] irq_status_q; // sticky events, write one to clear
    logic [1:0] irq_mask_q;
    det_state_e det_state_q; // armed until a hit, then locked
    logic cond_prev_q; // condition one cycle ago, for edge mode
    logic [DCW-1:0] div_q; // clock divided by six
    logic div_tick;
    logic filt_tick;
    logic filt_bypass;
    logic [7:0] keys_sync; // synchronised, unfiltered
    logic [7:0] keys; // synchronised and filtered
    logic masked_eq;
    logic cond;
    logic hit;
    logic wake_d;
    logic [31:0] rdata_d;
    logic addr_ok;
    logic setup;
    logic wr_access;
    logic wr_ctrl;
    logic wr_pattern;
    logic wr_mask;
    logic wr_irqen;
    logic wr_status;
    logic wr_imask;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic key_irq_q;
    logic wake_q;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // sample ticks for the filter
    // a free-running divider is cheaper than restarting it per key change
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_q <= '0;
        end else if (div_q == DCW'(`KPI_DIV_RATIO - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign div_tick = (div_q == DCW'(`KPI_DIV_RATIO - 1));

    // pick the sampling source
    always_comb begin
        filt_tick = 1'b0;
        filt_bypass = 1'b0;
        case (key_filter_select_q)
            FILT_OFF: filt_bypass = 1'b1; // RULE10
            FILT_SYSCLK: filt_tick = 1'b1; // RULE10
            FILT_DIV6: filt_tick = div_tick; // RULE10
            FILT_BAUD: filt_tick = baud_tick_in; // RULE10
            default: filt_bypass = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // one synchroniser and filter per key input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_KEYS; gi++) begin : g_key
            key_input_filter #(
                .FILTER_TICKS(`KPI_FILTER_TICKS)
            ) u_filt (
                .ref_clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .pin_in(keypad_input_in[gi]),
                .tick_in(filt_tick),
                .bypass_in(filt_bypass),
                .sync_out(keys_sync[gi]),
                .level_out(keys[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // comparison: disabled inputs are forced equal on both sides
    assign masked_eq = ((keys & key_input_enable_mask_q) ==
                        (key_match_pattern_q & key_input_enable_mask_q)); // RULE1 RULE2 RULE3
    assign cond = match_polarity_select_q ? masked_eq : ~masked_eq; // RULE6
    // a hit only while armed; edge mode also needs the condition newly true
    assign hit = (det_state_q == DET_ARMED) &&
                 (key_edge_mode_select_q ? (cond && !cond_prev_q) : cond); // RULE11 RULE4

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, answer registered in the setup cycle
    assign setup = psel_in && !penable_in;
    assign wr_access = psel_in && penable_in && pready_q && pwrite_in && !pslverr_q;
    assign wr_ctrl = wr_access && (paddr_in == ADDR_W'(`KPI_OFF_CTRL)) && pstrb_in[0];
    assign wr_pattern = wr_access && (paddr_in == ADDR_W'(`KPI_OFF_PATTERN)) && pstrb_in[0];
    assign wr_mask = wr_access && (paddr_in == ADDR_W'(`KPI_OFF_MASK)) && pstrb_in[0];
    assign wr_irqen = wr_access && (paddr_in == ADDR_W'(`KPI_OFF_IRQEN)) && pstrb_in[0];
    assign wr_status = wr_access && (paddr_in == ADDR_W'(`KPI_OFF_STATUS)) && pstrb_in[0];
    assign wr_imask = wr_access && (paddr_in == ADDR_W'(`KPI_OFF_IMASK)) && pstrb_in[0];

    // read mux; reserved bits read zero, unmapped addresses answer an error
    always_comb begin
        rdata_d = 32'h0;
        addr_ok = 1'b1;
        case (paddr_in)
            ADDR_W'(`KPI_OFF_CTRL): begin
                rdata_d[`KPI_CTRL_FILT_HI:`KPI_CTRL_FILT_LO] = key_filter_select_q;
                rdata_d[`KPI_CTRL_EDGE] = key_edge_mode_select_q;
                rdata_d[`KPI_CTRL_POL] = match_polarity_select_q;
                rdata_d[`KPI_CTRL_FLAG] = key_match_flag_q;
            end
            ADDR_W'(`KPI_OFF_PATTERN): rdata_d[7:0] = key_match_pattern_q;
            ADDR_W'(`KPI_OFF_MASK): rdata_d[7:0] = key_input_enable_mask_q;
            ADDR_W'(`KPI_OFF_IRQEN): begin
                rdata_d[`KPI_IRQEN_KEY] = key_irq_enable_q;
                rdata_d[`KPI_IRQEN_GLOBAL] = global_irq_enable_q;
            end
            ADDR_W'(`KPI_OFF_STATUS): rdata_d[1:0] = irq_status_q;
            ADDR_W'(`KPI_OFF_IMASK): rdata_d[1:0] = irq_mask_q;
            ADDR_W'(`KPI_OFF_INPUTS): rdata_d[7:0] = keys_sync;
            default: addr_ok = 1'b0;
        endcase
    end

    // bus answer flops
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                prdata_q <= pwrite_in ? 32'h0 : rdata_d;
                pslverr_q <= !addr_ok;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_match_pattern_q <= `KPI_RST_PATTERN; // RULE13
            key_input_enable_mask_q <= `KPI_RST_MASK;
            match_polarity_select_q <= 1'b0;
            key_edge_mode_select_q <= 1'b0;
            key_filter_select_q <= FILT_OFF;
            key_irq_enable_q <= 1'b0;
            global_irq_enable_q <= 1'b0;
            irq_mask_q <= 2'h0;
        end else begin
            if (wr_pattern) begin
                key_match_pattern_q <= pwdata_in[7:0]; // RULE3
            end
            if (wr_mask) begin
                key_input_enable_mask_q <= pwdata_in[7:0]; // RULE2
            end
            if (wr_ctrl) begin
                match_polarity_select_q <= pwdata_in[`KPI_CTRL_POL];
                key_edge_mode_select_q <= pwdata_in[`KPI_CTRL_EDGE];
                key_filter_select_q <=
                    filter_mode_e'(pwdata_in[`KPI_CTRL_FILT_HI:`KPI_CTRL_FILT_LO]);
            end
            if (wr_irqen) begin
                key_irq_enable_q <= pwdata_in[`KPI_IRQEN_KEY];
                global_irq_enable_q <= pwdata_in[`KPI_IRQEN_GLOBAL];
            end
            if (wr_imask) begin
                irq_mask_q <= pwdata_in[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // detector state: a hit locks it until software rewrites the pattern,
    // so a key held down raises one event and not a storm
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            det_state_q <= DET_ARMED;
            cond_prev_q <= 1'b0;
        end else begin
            cond_prev_q <= cond;
            case (det_state_q)
                DET_ARMED: begin
                    if (hit && !wr_pattern) begin
                        det_state_q <= DET_LOCKED;
                    end
                end
                DET_LOCKED: begin
                    if (wr_pattern) begin
                        det_state_q <= DET_ARMED; // RULE8
                    end
                end
                default: det_state_q <= DET_ARMED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // match flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_match_flag_q <= `KPI_RST_FLAG; // RULE12
        end else if (hit) begin
            key_match_flag_q <= 1'b1; // RULE4
        end else if (wr_ctrl && !pwdata_in[`KPI_CTRL_FLAG]) begin
            key_match_flag_q <= 1'b0; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // requests, all registered
    assign wake_d = key_match_flag_q && key_irq_enable_q && (idle_in || powerdown_in); // RULE9

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_irq_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            key_irq_q <= key_match_flag_q && key_irq_enable_q && global_irq_enable_q; // RULE5
            wake_q <= wake_d; // RULE9
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // sticky status: an event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_status_q <= `KPI_RST_STATUS;
        end else begin
            irq_status_q <= (irq_status_q & ~({2{wr_status}} & pwdata_in[1:0])) |
                            {wake_d && !wake_q, hit};
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign key_irq_out = key_irq_q;
    assign wake_out = wake_q;
    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_hit_sets_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        hit |=> key_match_flag_q) // RULE4
        else $error("hit did not set the flag");

    a_flag_sw_clear: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(key_match_flag_q) |-> $past(wr_ctrl) && !$past(pwdata_in[0])) // RULE12
        else $error("flag cleared without a software write of zero");

    a_irq_gating: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        key_irq_q |-> $past(key_match_flag_q) && $past(key_irq_enable_q)
                      && $past(global_irq_enable_q)) // RULE5
        else $error("request without flag and both enables");

    a_pattern_rearm: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        wr_pattern |=> det_state_q == DET_ARMED) // RULE8
        else $error("pattern write did not rearm");

    a_single_event: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        hit && !wr_pattern |=> !hit [*2]) // RULE8
        else $error("second event without pattern rewrite");

    a_mask_none: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        key_input_enable_mask_q == 8'h00 && !match_polarity_select_q |-> !hit) // RULE2
        else $error("event with all inputs disabled");

    a_polarity_sense: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        hit |-> masked_eq == match_polarity_select_q) // RULE6
        else $error("event with wrong polarity");

    a_edge_only: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        hit && key_edge_mode_select_q |-> !cond_prev_q && cond) // RULE11
        else $error("edge mode event without a rising condition");

    a_wake_cause: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        wake_q |-> $past(key_match_flag_q) && $past(idle_in || powerdown_in)) // RULE9
        else $error("wake without flag in a sleep mode");

    a_apb_ready: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        psel_in && !penable_in |=> pready_q ##1 !pready_q || (psel_in && !penable_in))
        else $error("apb answer not one cycle after setup");
endmodule

// ---- verilog/kpi_defines.svh ----
/*
 * constants of the keypad pattern interrupt unit: register offsets,
 * field positions, reset values and timing counts.
 * assumes it is included by bare name after the package is compiled.
 */
//
// How it works
// RULE1: eight inputs compared as one group
// RULE2: mask bit selects which inputs take part
// RULE3: stored eight-bit pattern compared with inputs
// RULE4: hardware sets flag when condition true
// RULE5: request needs flag, key enable, global enable
// RULE6: polarity bit picks equal or not equal
// RULE7: software loads all ones, not-equal for keyboards
// RULE8: pattern write rearms detector; software rewrites it
// RULE9: interrupt wakes from idle and power-down
// RULE10: filter field: off, 3 clocks, 3x clk/6, 3x baud
// RULE11: edge mode bit picks level or edge detection
// RULE12: flag resets to one, cleared only by software
// RULE13: pattern register resets to all ones
// RULE14: inputs synchronised before the masked comparison
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define KPI_OFF_CTRL 12'h000
`define KPI_OFF_PATTERN 12'h004
`define KPI_OFF_MASK 12'h008
`define KPI_OFF_IRQEN 12'h00c
`define KPI_OFF_STATUS 12'h010
`define KPI_OFF_IMASK 12'h014
`define KPI_OFF_INPUTS 12'h018

////////////////////////////////////////////////////////////////////////////////
// field positions
`define KPI_CTRL_FLAG 0
`define KPI_CTRL_POL 1
`define KPI_CTRL_EDGE 5
`define KPI_CTRL_FILT_LO 6
`define KPI_CTRL_FILT_HI 7
`define KPI_IRQEN_KEY 0
`define KPI_IRQEN_GLOBAL 1
`define KPI_STAT_MATCH 0
`define KPI_STAT_WAKE 1

////////////////////////////////////////////////////////////////////////////////
// reset values
`define KPI_RST_PATTERN 8'hff
`define KPI_RST_MASK 8'h00
`define KPI_RST_FLAG 1'b1
`define KPI_RST_FILTER 2'h0
`define KPI_RST_STATUS 2'h0

////////////////////////////////////////////////////////////////////////////////
// timing counts
`define KPI_DIV_RATIO 6
`define KPI_FILTER_TICKS 3

`endif

// ---- verilog/kpi_pkg.sv ----
/*
 * types shared by the keypad pattern interrupt files.
 * assumes nothing beyond a systemverilog compiler.
 */
package kpi_pkg;
    // filter sampling source, encoding fixed by the control field
    typedef enum logic [1:0] {
        FILT_OFF = 2'h0,
        FILT_SYSCLK = 2'h1,
        FILT_DIV6 = 2'h2,
        FILT_BAUD = 2'h3
    } filter_mode_e;
    // detector state, one-hot
    typedef enum logic [1:0] {
        DET_ARMED = 2'h1,
        DET_LOCKED = 2'h2
    } det_state_e;
endpackage
